// ==== cbsb_top.sv ====
// Purpose: Card-bus secondary status and bus-number configuration bank, two functions.
// Assumes: Configuration accesses arrive as one-cycle strobes with a byte address and
//          byte enables; event inputs other than the CSERR pins are on mclk.
// Notes:   Read data and acknowledge appear one cycle after the strobe.
`timescale 1ns/1ps
module cbsb_top
  import cbsb_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                cfg_wr,
  input  wire logic                cfg_rd,
  input  wire logic                cfg_func,
  input  wire logic [CFG_AW-1:0]   cfg_addr,
  input  wire logic [CFG_BEW-1:0]  cfg_be,
  input  wire logic [CFG_DW-1:0]   cfg_wdata,
  output logic      [CFG_DW-1:0]   cfg_rdata,
  output logic                     cfg_ack,
  input  wire logic [NUM_FUNC-1:0] sec_cserr_n,
  output logic      [NUM_FUNC-1:0] sec_cserr_oe,
  input  wire logic [NUM_FUNC-1:0] sec_parity_err,
  input  wire logic [NUM_FUNC-1:0] sec_master_abort,
  input  wire logic [NUM_FUNC-1:0] sec_tabort_rcvd,
  input  wire logic [NUM_FUNC-1:0] sec_tabort_sent,
  input  wire logic [NUM_FUNC-1:0] sec_cperr,
  input  wire logic [NUM_FUNC-1:0] sec_bus_master,
  input  wire logic [NUM_FUNC-1:0] parity_resp_en,
  input  wire logic                fwd_req,
  input  wire logic                fwd_func,
  input  wire logic [BUS_W-1:0]    fwd_bus,
  output logic                     fwd_done,
  output logic                     fwd_local,
  output logic                     fwd_pass
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper, used by both the write and the read paths.
  function automatic logic dword_hit(input logic [CFG_AW-1:0] addr,
                                     input logic [CFG_AW-1:0] off);
    dword_hit = (addr[CFG_AW-1:2] == off[CFG_AW-1:2]);
  endfunction

  localparam int STAT_LANE_LO = SEC_STATUS_OFF[1:0];
  localparam int PRI_LANE     = PRI_BUS_OFF[1:0];
  localparam int SEC_LANE     = SEC_BUS_OFF[1:0];
  localparam int SUB_LANE     = SUB_BUS_OFF[1:0];

  logic [BUS_W-1:0]  pri_bus_q [NUM_FUNC];
  logic [BUS_W-1:0]  sec_bus_q [NUM_FUNC];
  logic [BUS_W-1:0]  sub_bus_q [NUM_FUNC];
  logic [STAT_W-1:0] status_v  [NUM_FUNC];
  cbsb_fwd_t         decision  [NUM_FUNC];
  logic              stat_hit;
  logic              bus_hit;

  assign stat_hit = dword_hit(cfg_addr, SEC_STATUS_OFF);
  assign bus_hit  = dword_hit(cfg_addr, PRI_BUS_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Per-function logic: each function owns its registers, so a write aimed
  // at one function can never disturb the other.
  genvar f;
  generate
    for (f = 0; f < NUM_FUNC; f++) begin : g_func
      logic                   sel;
      logic [SYNC_STAGES-1:0] cserr_sync_q;
      logic                   serr_seen;
      cbsb_stat_if            st_if ();

      assign sel = (cfg_func == 1'(f));  // RULE_17

      // Bus-number registers, byte-lane writable.
      always_ff @(posedge mclk) begin
        if (srst) begin
          pri_bus_q[f] <= BUS_NUM_RESET;  // RULE_14
          sec_bus_q[f] <= BUS_NUM_RESET;  // RULE_15
          sub_bus_q[f] <= BUS_NUM_RESET;  // RULE_18
        end else if (cfg_wr && sel && bus_hit) begin
          if (cfg_be[PRI_LANE]) begin
            pri_bus_q[f] <= cfg_wdata[PRI_LANE*BUS_W +: BUS_W];  // RULE_14
          end
          if (cfg_be[SEC_LANE]) begin
            sec_bus_q[f] <= cfg_wdata[SEC_LANE*BUS_W +: BUS_W];  // RULE_15 RULE_17
          end
          if (cfg_be[SUB_LANE]) begin
            sub_bus_q[f] <= cfg_wdata[SUB_LANE*BUS_W +: BUS_W];  // RULE_18
          end
        end
      end

      // CSERR comes from the card's own pin, so it is synchronised first.
      // The first stage feeds only the second; the last two must agree.
      always_ff @(posedge mclk) begin
        if (srst) begin
          cserr_sync_q <= {SYNC_STAGES{1'b1}};
        end else begin
          cserr_sync_q <= {cserr_sync_q[SYNC_STAGES-2:0], sec_cserr_n[f]};
        end
      end

      assign serr_seen = ~cserr_sync_q[SYNC_STAGES-1] & ~cserr_sync_q[SYNC_STAGES-2];  // RULE_03

      // Event strobes into the status bank.
      assign st_if.evt_parity     = sec_parity_err[f];  // RULE_02
      assign st_if.evt_serr       = serr_seen;  // RULE_03
      assign st_if.evt_mabort     = sec_master_abort[f];  // RULE_04
      assign st_if.evt_tabort_rcv = sec_tabort_rcvd[f];  // RULE_05
      assign st_if.evt_tabort_sig = sec_tabort_sent[f];  // RULE_06
      assign st_if.evt_dpar       = sec_cperr[f] & sec_bus_master[f] & parity_resp_en[f];  // RULE_08

      // Write-one-to-clear mask, gated by the upper two byte lanes.
      always_comb begin
        st_if.clr_mask = '0;
        if (cfg_wr && sel && stat_hit) begin
          if (cfg_be[STAT_LANE_LO]) begin
            st_if.clr_mask[0 +: BUS_W] = cfg_wdata[STAT_LANE_LO*BUS_W +: BUS_W];  // RULE_01
          end
          if (cfg_be[STAT_LANE_LO+1]) begin
            st_if.clr_mask[BUS_W +: BUS_W] = cfg_wdata[(STAT_LANE_LO+1)*BUS_W +: BUS_W];  // RULE_01
          end
        end
      end

      cbsb_status u_status (
        .mclk (mclk),
        .srst (srst),
        .st   (st_if.bank)
      );

      assign status_v[f] = st_if.status;

      cbsb_fwd u_fwd (
        .pri_bus  (pri_bus_q[f]),
        .sec_bus  (sec_bus_q[f]),
        .sub_bus  (sub_bus_q[f]),
        .req_bus  (fwd_bus),
        .decision (decision[f])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // The bridge only watches CSERR; its enable is a flop held low forever.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sec_cserr_oe <= '0;  // RULE_03
    end else begin
      sec_cserr_oe <= '0;  // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Neighbouring bytes in the same dwords belong to registers kept
  // elsewhere and read as zero here; unmapped dwords also read zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_rdata <= RDATA_ZERO;
    end else if (cfg_rd) begin
      cfg_rdata <= RDATA_ZERO;
      if (stat_hit) begin
        cfg_rdata[STAT_LANE_LO*BUS_W +: STAT_W] <= status_v[cfg_func];  // RULE_13
      end else if (bus_hit) begin
        cfg_rdata[PRI_LANE*BUS_W +: BUS_W] <= pri_bus_q[cfg_func];  // RULE_14
        cfg_rdata[SEC_LANE*BUS_W +: BUS_W] <= sec_bus_q[cfg_func];  // RULE_15
        cfg_rdata[SUB_LANE*BUS_W +: BUS_W] <= sub_bus_q[cfg_func];  // RULE_18
      end
    end
  end

  // Every access, mapped or not, is acknowledged once, one cycle later.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd | cfg_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding result, registered so the outputs leave from flops. The
  // decision uses the bus numbers as they stand in the request cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      fwd_done  <= 1'b0;
      fwd_local <= 1'b0;
      fwd_pass  <= 1'b0;
    end else begin
      fwd_done  <= fwd_req;
      fwd_local <= fwd_req && (decision[fwd_func] == FWD_LOCAL);  // RULE_16 RULE_19
      fwd_pass  <= fwd_req && (decision[fwd_func] == FWD_PASS);  // RULE_16 RULE_19
    end
  end

endmodule

// ==== cbsb_pkg.sv ====
// Purpose: Shared constants and types for the card-bus secondary status and bus-number bank.
// Assumes: One clock (mclk), synchronous active-high reset, two controller functions.
// Notes:   Each rule below is tagged at the logic that carries it out.
// Contract
// RULE_01 - Writing one clears a status event bit; writing zero leaves it.
// RULE_02 - Bit 15 sets on secondary address or data parity error.
// RULE_03 - Bit 14 sets when a card asserts CSERR; bridge never drives CSERR.
// RULE_04 - Bit 13 sets when a bridge-initiated secondary cycle master-aborts.
// RULE_05 - Bit 12 sets when a bridge-initiated secondary cycle is target-aborted.
// RULE_06 - Bit 11 sets when bridge, as secondary target, signals target abort.
// RULE_07 - Bits 10 to 9 read constant 01b, medium select timing.
// RULE_08 - Bit 8 sets on CPERR while bridge masters and parity response enabled.
// RULE_09 - Bit 7 reads zero; no fast back-to-back acceptance.
// RULE_10 - Bit 6 reads zero; no user-definable features.
// RULE_11 - Bit 5 reads zero; secondary clock at most 33 MHz.
// RULE_12 - Bits 4 to 0 are reserved and read zero.
// RULE_13 - Status at offset 16h resets to 0200h with events clear.
// RULE_14 - Primary bus number, 8-bit read/write at 18h, resets to zero.
// RULE_15 - Secondary bus number, 8-bit read/write at 19h, resets to zero.
// RULE_16 - Bus numbers are compared to decide configuration cycle forwarding.
// RULE_17 - Each function keeps its own independent bus-number registers.
// RULE_18 - Subordinate bus number, 8-bit read/write at 1Ah, resets to zero.
// RULE_19 - Secondary number goes local; above it up to subordinate passes unchanged.
package cbsb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space layout.
  localparam int           NUM_FUNC        = 2;
  localparam int           CFG_AW          = 8;
  localparam int           CFG_DW          = 32;
  localparam int           CFG_BEW         = 4;
  localparam int           BUS_W           = 8;
  localparam int           STAT_W          = 16;
  localparam logic [7:0]   SEC_STATUS_OFF  = 8'h16;
  localparam logic [7:0]   PRI_BUS_OFF     = 8'h18;
  localparam logic [7:0]   SEC_BUS_OFF     = 8'h19;
  localparam logic [7:0]   SUB_BUS_OFF     = 8'h1A;
  localparam logic [7:0]   BUS_NUM_RESET   = 8'h00;
  localparam logic [15:0]  STATUS_RESET    = 16'h0200;
  localparam logic [31:0]  RDATA_ZERO      = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions and hardwired fields.
  localparam int           BIT_PARITY      = 15;
  localparam int           BIT_SERR        = 14;
  localparam int           BIT_MABORT      = 13;
  localparam int           BIT_TABORT_RCV  = 12;
  localparam int           BIT_TABORT_SIG  = 11;
  localparam int           BIT_DEVSEL_HI   = 10;
  localparam int           BIT_DEVSEL_LO   = 9;
  localparam int           BIT_DPAR        = 8;
  localparam logic [1:0]   DEVSEL_MEDIUM   = 2'h1;
  localparam logic [15:0]  STATUS_RC_MASK  = 16'hF900;

  // Input synchroniser depth for card pins.
  localparam int           SYNC_STAGES     = 3;

  // Forwarding decision for a configuration cycle.
  typedef enum logic [1:0] {FWD_NONE, FWD_LOCAL, FWD_PASS} cbsb_fwd_t;

endpackage

// ==== cbsb_stat_if.sv ====
// Purpose: Carries one function's event strobes and clear mask to its status bank.
// Assumes: All signals on mclk.
// Notes:   Events are one-cycle or level; a level simply keeps the bit set.
`timescale 1ns/1ps
interface cbsb_stat_if;
  import cbsb_pkg::*;
  logic              evt_parity;
  logic              evt_serr;
  logic              evt_mabort;
  logic              evt_tabort_rcv;
  logic              evt_tabort_sig;
  logic              evt_dpar;
  logic [STAT_W-1:0] clr_mask;
  logic [STAT_W-1:0] status;

  modport ctl (output evt_parity, evt_serr, evt_mabort, evt_tabort_rcv, evt_tabort_sig, evt_dpar,
               output clr_mask, input status);
  modport bank (input evt_parity, evt_serr, evt_mabort, evt_tabort_rcv, evt_tabort_sig, evt_dpar,
                input clr_mask, output status);
endinterface

// ==== cbsb_status.sv ====
// Purpose: Secondary status register of one controller function.
// Assumes: clr_mask already gated by write strobe and byte lanes.
// Notes:   Set beats clear in the same cycle so no event is lost.
`timescale 1ns/1ps
module cbsb_status
  import cbsb_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  srst,
  cbsb_stat_if.bank  st
);

  logic [STAT_W-1:0] sticky_q;
  logic [STAT_W-1:0] set_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Map incoming events onto their bit positions.
  always_comb begin
    set_vec                 = '0;
    set_vec[BIT_PARITY]     = st.evt_parity;      // RULE_02
    set_vec[BIT_SERR]       = st.evt_serr;        // RULE_03
    set_vec[BIT_MABORT]     = st.evt_mabort;      // RULE_04
    set_vec[BIT_TABORT_RCV] = st.evt_tabort_rcv;  // RULE_05
    set_vec[BIT_TABORT_SIG] = st.evt_tabort_sig;  // RULE_06
    set_vec[BIT_DPAR]       = st.evt_dpar;        // RULE_08
  end

  // Sticky bits: write-one clears, but a fresh event in that cycle wins.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sticky_q <= STATUS_RESET & STATUS_RC_MASK;  // RULE_13
    end else begin
      sticky_q <= ((sticky_q & ~st.clr_mask) | set_vec) & STATUS_RC_MASK;  // RULE_01
    end
  end

  // Hardwired fields; bits 7..0 stay zero through the mask.
  always_comb begin
    st.status                              = sticky_q;  // RULE_09 RULE_10 RULE_11 RULE_12
    st.status[BIT_DEVSEL_HI:BIT_DEVSEL_LO] = DEVSEL_MEDIUM;  // RULE_07
  end

endmodule

// ==== cbsb_fwd.sv ====
// Purpose: Decides where a primary configuration cycle goes for one function.
// Assumes: Bus numbers programmed by software; no check that they are ordered.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module cbsb_fwd
  import cbsb_pkg::*;
(
  input  wire logic [BUS_W-1:0] pri_bus,
  input  wire logic [BUS_W-1:0] sec_bus,
  input  wire logic [BUS_W-1:0] sub_bus,
  input  wire logic [BUS_W-1:0] req_bus,
  output cbsb_fwd_t             decision
);

  ////////////////////////////////////////////////////////////////////////////
  // A cycle to the primary number is ours, never forwarded; the reset state
  // of all zeros therefore forwards nothing until software programs numbers.
  always_comb begin
    if (req_bus == pri_bus) begin
      decision = FWD_NONE;  // RULE_16
    end else if (req_bus == sec_bus) begin
      decision = FWD_LOCAL;  // RULE_19
    end else if ((req_bus > sec_bus) && (req_bus <= sub_bus)) begin
      decision = FWD_PASS;  // RULE_19
    end else begin
      decision = FWD_NONE;  // RULE_16
    end
  end

endmodule

// ==== cbsb_monitor.sv ====
// Purpose: Concurrent port checks for the card-bus status and bus-number bank.
// Assumes: One mclk domain; srst synchronous and active high.
// Notes:   Status lives in dword 14h, bus numbers in dword 18h.
`timescale 1ns/1ps
module cbsb_monitor
  import cbsb_pkg::*;
(
  input wire logic                mclk,
  input wire logic                srst,
  input wire logic                cfg_wr,
  input wire logic                cfg_rd,
  input wire logic                cfg_func,
  input wire logic [CFG_AW-1:0]   cfg_addr,
  input wire logic [CFG_DW-1:0]   cfg_rdata,
  input wire logic                cfg_ack,
  input wire logic [NUM_FUNC-1:0] sec_cserr_oe,
  input wire logic [NUM_FUNC-1:0] sec_master_abort,
  input wire logic                fwd_req,
  input wire logic                fwd_done,
  input wire logic                fwd_local,
  input wire logic                fwd_pass
);
  ////////////////////////////////////////
  // Checks run on mclk and sleep while reset is held.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // A status read, and a function 0 master abort followed by a read with no clear between.
  sequence stat_rd;
    cfg_rd && cfg_addr[7:2] == 6'h05;
  endsequence
  sequence abort_then_rd;
    sec_master_abort[0] ##1 !cfg_wr ##1 stat_rd ##0 !cfg_func;
  endsequence
  ack_follow_a: assert property (cfg_ack == $past(cfg_rd || cfg_wr))
    else $error("Ack not one cycle after strobe.");
  cserr_quiet_a: assert property (sec_cserr_oe == '0)
    else $error("Bridge drives the system error pin.");
  devsel_fixed_a: assert property (stat_rd |=> cfg_rdata[26:25] == DEVSEL_MEDIUM)
    else $error("Select timing field is not medium.");
  fixed_zero_a: assert property (stat_rd |=> cfg_rdata[23:0] == '0)
    else $error("Hardwired status bits are not zero.");
  abort_seen_a: assert property (abort_then_rd |=> cfg_rdata[29])
    else $error("Master abort not recorded.");
  fwd_answer_a: assert property (fwd_done == $past(fwd_req))
    else $error("Forward answer not one cycle after request.");
  fwd_excl_a: assert property ((fwd_local || fwd_pass) |-> fwd_done && !(fwd_local && fwd_pass))
    else $error("Forward decision flags inconsistent.");
  unmapped_zero_a: assert property (cfg_rd && !(cfg_addr[7:2] inside {6'h05, 6'h06}) |=> cfg_rdata == '0)
    else $error("Unmapped read returned nonzero.");
endmodule

bind cbsb_top cbsb_monitor u_cbsb_monitor (
  .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .sec_cserr_oe(sec_cserr_oe), .sec_master_abort(sec_master_abort),
  .fwd_req(fwd_req), .fwd_done(fwd_done), .fwd_local(fwd_local), .fwd_pass(fwd_pass)
);

// ==== cbsb_card_model.sv ====
// Purpose: Behavioural secondary-bus side for both controller functions.
// Assumes: The bench calls raise between its own accesses.
// Notes:   Conditions last whole mclk cycles; bus phases are not modelled.
`timescale 1ns/1ps
module cbsb_card_model
  import cbsb_pkg::*;
(
  input  wire logic           mclk,
  output logic [NUM_FUNC-1:0] sec_cserr_n,
  output logic [NUM_FUNC-1:0] sec_parity_err,
  output logic [NUM_FUNC-1:0] sec_master_abort,
  output logic [NUM_FUNC-1:0] sec_tabort_rcvd,
  output logic [NUM_FUNC-1:0] sec_tabort_sent,
  output logic [NUM_FUNC-1:0] sec_cperr,
  output logic [NUM_FUNC-1:0] sec_bus_master
);
  ////////////////////////////////////////
  // Idle: the error pin rests at its pull-up level, every other line quiet.
  initial begin
    sec_cserr_n      = '1;
    sec_parity_err   = '0;
    sec_master_abort = '0;
    sec_tabort_rcvd  = '0;
    sec_tabort_sent  = '0;
    sec_cperr        = '0;
    sec_bus_master   = '0;
  end
  // Holds one condition on function f for n cycles, then releases all lines at once.
  task automatic raise(input int f, input int kind, input int n);
    @(posedge mclk);
    case (kind)
      0: sec_parity_err[f] <= 1'b1;
      1: sec_master_abort[f] <= 1'b1;
      2: sec_tabort_rcvd[f] <= 1'b1;
      3: sec_tabort_sent[f] <= 1'b1;
      4: sec_bus_master[f] <= 1'b1;
      6: sec_cserr_n[f] <= 1'b0;
      default: ;
    endcase
    if (kind == 4 || kind == 5) sec_cperr[f] <= 1'b1;
    repeat (n) @(posedge mclk);
    sec_cserr_n      <= '1;
    sec_parity_err   <= '0;
    sec_master_abort <= '0;
    sec_tabort_rcvd  <= '0;
    sec_tabort_sent  <= '0;
    sec_cperr        <= '0;
    sec_bus_master   <= '0;
  endtask
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the card-bus status and bus-number bank.
// Assumes: One access in flight at a time; inputs change by NBA at posedge.
// Notes:   Expected values are built from the register layout only.
`timescale 1ns/1ps
module tb;
  import cbsb_pkg::*;
  logic                mclk, srst, cfg_wr, cfg_rd, cfg_func, cfg_ack, fwd_req, fwd_func, fwd_done, fwd_local, fwd_pass;
  logic [CFG_AW-1:0]   cfg_addr;
  logic [CFG_BEW-1:0]  cfg_be;
  logic [CFG_DW-1:0]   cfg_wdata, cfg_rdata, got;
  logic [BUS_W-1:0]    fwd_bus;
  logic [NUM_FUNC-1:0] sec_cserr_n, sec_cserr_oe, sec_parity_err, sec_master_abort, sec_tabort_rcvd;
  logic [NUM_FUNC-1:0] sec_tabort_sent, sec_cperr, sec_bus_master, parity_resp_en;
  logic [BUS_W-1:0]    fb [6] = '{8'h10, 8'h1F, 8'h20, 8'h21, 8'h30, 8'h31};
  logic [1:0]          fe [6] = '{2'b00, 2'b00, 2'b10, 2'b01, 2'b01, 2'b00};
  int                  eb [4] = '{15, 13, 12, 11};
  int                  miscompares, n_checks;

  ////////////////////////////////////////
  cbsb_top u_cbsb_top (
    .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .sec_cserr_n(sec_cserr_n),
    .sec_cserr_oe(sec_cserr_oe), .sec_parity_err(sec_parity_err), .sec_master_abort(sec_master_abort),
    .sec_tabort_rcvd(sec_tabort_rcvd), .sec_tabort_sent(sec_tabort_sent), .sec_cperr(sec_cperr),
    .sec_bus_master(sec_bus_master), .parity_resp_en(parity_resp_en), .fwd_req(fwd_req), .fwd_func(fwd_func),
    .fwd_bus(fwd_bus), .fwd_done(fwd_done), .fwd_local(fwd_local), .fwd_pass(fwd_pass)
  );
  cbsb_card_model u_cbsb_card_model (
    .mclk(mclk), .sec_cserr_n(sec_cserr_n), .sec_parity_err(sec_parity_err), .sec_master_abort(sec_master_abort),
    .sec_tabort_rcvd(sec_tabort_rcvd), .sec_tabort_sent(sec_tabort_sent), .sec_cperr(sec_cperr),
    .sec_bus_master(sec_bus_master)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One strobe, then a bounded wait for ack; read data is taken at the ack edge.
  task automatic acc(input logic wr, input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    int k;
    @(posedge mclk);
    cfg_wr    <= wr;
    cfg_rd    <= !wr;
    cfg_func  <= f;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cfg_ack !== 1'b1 && k < 8);
    if (cfg_ack !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    got = cfg_rdata;
  endtask
  task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, f, a, 4'h0, 32'h0);
    chk(got, e);
  endtask
  // Writing ones over the whole status dword clears every event bit.
  task automatic clr(input logic f);
    acc(1'b1, f, 8'h14, 4'hF, 32'hFFFF_FFFF);
  endtask
  // The decision is due exactly one cycle after the request edge.
  task automatic fwd(input logic f, input logic [7:0] b, input logic [1:0] e);
    @(posedge mclk);
    fwd_req  <= 1'b1;
    fwd_func <= f;
    fwd_bus  <= b;
    @(posedge mclk);
    fwd_req <= 1'b0;
    @(posedge mclk);
    chk({29'h0, fwd_done, fwd_local, fwd_pass}, {29'h0, 1'b1, e});
  endtask

  // Main sequence: reset values, bus numbers, forwarding, then each event source.
  initial begin
    logic [31:0] ex;
    {srst, cfg_wr, cfg_rd, cfg_func, fwd_req, fwd_func} = 6'h20;
    {cfg_addr, cfg_be, cfg_wdata, fwd_bus} = '0;
    parity_resp_en = 2'h3;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(0, 8'h14, 32'h0200_0000);
    rd(1, 8'h14, 32'h0200_0000);
    rd(0, 8'h18, 32'h0);
    acc(1'b1, 0, 8'h18, 4'h7, 32'hFF30_2010);
    rd(0, 8'h18, 32'h0030_2010);
    rd(1, 8'h18, 32'h0);
    acc(1'b1, 1, 8'h18, 4'h2, 32'h0000_4400);
    rd(1, 8'h18, 32'h0000_4400);
    rd(0, 8'h18, 32'h0030_2010);
    acc(1'b1, 0, 8'h40, 4'hF, 32'hFFFF_FFFF);
    rd(0, 8'h40, 32'h0);
    foreach (fb[i]) fwd(1'b0, fb[i], fe[i]);
    fwd(1'b1, 8'h44, 2'b10);
    foreach (eb[i]) begin
      ex = {16'h0200 | (16'h1 << eb[i]), 16'h0};
      u_cbsb_card_model.raise(0, i, 1);
      rd(0, 8'h14, ex);
      acc(1'b1, 0, 8'h14, 4'hC, 32'h0);
      rd(0, 8'h14, ex);
      clr(0);
      rd(0, 8'h14, 32'h0200_0000);
    end
    rd(1, 8'h14, 32'h0200_0000);
    u_cbsb_card_model.raise(1, 5, 2);
    rd(1, 8'h14, 32'h0200_0000);
    u_cbsb_card_model.raise(1, 4, 1);
    rd(1, 8'h14, 32'h0300_0000);
    clr(1);
    rd(1, 8'h14, 32'h0200_0000);
    parity_resp_en <= 2'h1;
    u_cbsb_card_model.raise(1, 4, 1);
    rd(1, 8'h14, 32'h0200_0000);
    u_cbsb_card_model.raise(1, 6, 6);
    rd(1, 8'h14, 32'h4200_0000);
    clr(1);
    rd(1, 8'h14, 32'h0200_0000);
    tally_and_finish();
  end
endmodule
